//--- verilog/homing_method_sequencer.sv
// homing sequencer: runs the selected method and fixes the origin
// assumes sensors and position are synchronous to clock, ON is high
//
// How it works
// - method zero does no homing; home switch and limits are active high.
// - method 17 searches like 1, origin at negative limit rising while moving negative.
// - method 18 searches like 2, origin at positive limit rising while moving positive.
// - methods 19-30 search like 3-14, origin at the home switch edge itself.
// - method 33 moves negative and takes the nearest index pulse as origin.
// - method 34 moves positive and takes the nearest index pulse as origin.
// - method 35 takes the present position as origin without moving.
// - method 1, limit off: fast negative, at limit rising stop, reverse slow positive.
// - method 1, after negative limit falls moving positive, latch next index pulse.
// - method 1, limit already on: start slow positive, await negative limit falling.
// - method 2, limit off: fast positive, at limit rising stop, reverse slow negative.
// - method 2, after positive limit falls moving negative, latch next index pulse.
// - method 2, limit already on: start slow negative, await positive limit falling.
// - method 3, switch off: fast positive, at rising stop, slow negative, index after fall.
// - method 3, switch on: slow negative, latch the index pulse after switch falls.
// - methods 3-6 and 19-22 stop with alarm at the limit in the direction of travel, never reverse.
`timescale 1ns/10ps
module homing_method_sequencer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host selection
  input wire logic [7:0] homingMethod,
  input wire logic homingRun,
  // sensors
  input wire logic homeSwitchInput,
  input wire logic negativeOvertravelInput,
  input wire logic positiveOvertravelInput,
  input wire logic indexPulse,
  input wire logic [homing_pkg::POSITION_W-1:0] actualPosition,
  // motion request
  output logic moveNegative,
  output logic movePositive,
  output logic fastSpeed,
  // status
  output logic homingBusy,
  output logic homingDone,
  output logic homingAlarm,
  output logic invalidMethod,
  // origin
  output logic [homing_pkg::POSITION_W-1:0] originPosition,
  output logic originValid
);
  sensor_edge_if homeEdge();
  sensor_edge_if negEdge();
  sensor_edge_if posEdge();
  sensor_edge_if idxEdge();

  sensor_edge homeDet (.clock(clock), .rst(rst), .sense(homeSwitchInput), .port(homeEdge));
  sensor_edge negDet (.clock(clock), .rst(rst), .sense(negativeOvertravelInput), .port(negEdge));
  sensor_edge posDet (.clock(clock), .rst(rst), .sense(positiveOvertravelInput), .port(posEdge));
  sensor_edge idxDet (.clock(clock), .rst(rst), .sense(indexPulse), .port(idxEdge));

  homing_pkg::home_state_e stateReg, stateNext;
  logic dirReg, dirNext;
  logic finalReg, finalNext;
  logic riseReg, riseNext;
  logic [1:0] selReg, selNext;
  logic useIndexReg, useIndexNext;
  logic reverseReg, reverseNext;
  logic bounceReg, bounceNext;
  logic fastApReg, fastApNext;
  logic [7:0] cntReg, cntNext;
  logic runPrevReg, runPrevNext;
  logic latchNow;
  logic startNow;

  logic moveNegNext, movePosNext, fastNext, busyNext, doneNext, alarmNext, invalidNext;

  // decode helpers
  logic [3:0] prof;
  logic [1:0] decSel;
  logic decLevel;
  logic decStartDir;
  logic isHome, isHomeEdge, isLimit;
  logic tgtRise, tgtFall;
  logic aheadLevel, aheadIsTarget;

  always_comb begin
    isHome = (homingMethod >= homing_pkg::METHOD_HOME_FIRST) &&
      (homingMethod <= homing_pkg::METHOD_HOME_LAST);
    isHomeEdge = (homingMethod >= homing_pkg::METHOD_HOME_EDGE_FIRST) &&
      (homingMethod <= homing_pkg::METHOD_HOME_EDGE_LAST);
    isLimit = (homingMethod == homing_pkg::METHOD_NEG_LIMIT_INDEX) ||
      (homingMethod == homing_pkg::METHOD_POS_LIMIT_INDEX) ||
      (homingMethod == homing_pkg::METHOD_NEG_LIMIT_EDGE) ||
      (homingMethod == homing_pkg::METHOD_POS_LIMIT_EDGE);
    prof = homing_pkg::methodProfile(homingMethod);
    // deceleration point of methods 1/2 is the overtravel switch itself
    if (homingMethod == homing_pkg::METHOD_NEG_LIMIT_INDEX ||
        homingMethod == homing_pkg::METHOD_NEG_LIMIT_EDGE) begin
      decSel = homing_pkg::SENSE_NEG;
      decLevel = negEdge.level;
    end else if (homingMethod == homing_pkg::METHOD_POS_LIMIT_INDEX ||
        homingMethod == homing_pkg::METHOD_POS_LIMIT_EDGE) begin
      decSel = homing_pkg::SENSE_POS;
      decLevel = posEdge.level;
    end else begin
      decSel = homing_pkg::SENSE_HOME;
      decLevel = homeEdge.level;
    end
    decStartDir = decLevel ? prof[homing_pkg::PROF_DIR_ON] : prof[homing_pkg::PROF_DIR_OFF];
  end

  // edges of the sensor selected for this run
  always_comb begin
    if (selReg == homing_pkg::SENSE_NEG) begin
      tgtRise = negEdge.rise;
      tgtFall = negEdge.fall;
    end else if (selReg == homing_pkg::SENSE_POS) begin
      tgtRise = posEdge.rise;
      tgtFall = posEdge.fall;
    end else begin
      tgtRise = homeEdge.rise;
      tgtFall = homeEdge.fall;
    end
    aheadLevel = dirReg ? posEdge.level : negEdge.level;
    aheadIsTarget = (selReg == homing_pkg::SENSE_NEG && !dirReg) ||
      (selReg == homing_pkg::SENSE_POS && dirReg);
  end

  // a run starts on the rise of the held control word
  assign startNow = homingRun & ~runPrevReg;

  always_comb begin
    stateNext = stateReg;
    dirNext = dirReg;
    finalNext = finalReg;
    riseNext = riseReg;
    selNext = selReg;
    useIndexNext = useIndexReg;
    reverseNext = reverseReg;
    bounceNext = bounceReg;
    fastApNext = fastApReg;
    cntNext = cntReg;
    runPrevNext = homingRun;
    latchNow = 1'b0;
    case (stateReg)
      homing_pkg::ST_IDLE: begin
        if (startNow) begin
          if (homingMethod == homing_pkg::METHOD_NONE) begin
            stateNext = homing_pkg::ST_FINISHED;
          end else if (homingMethod == homing_pkg::METHOD_HERE) begin
            latchNow = 1'b1;
            stateNext = homing_pkg::ST_FINISHED;
          end else if (homingMethod == homing_pkg::METHOD_INDEX_NEG ||
              homingMethod == homing_pkg::METHOD_INDEX_POS) begin
            dirNext = (homingMethod == homing_pkg::METHOD_INDEX_POS);
            selNext = homing_pkg::SENSE_HOME;
            stateNext = homing_pkg::ST_INDEX;
          end else if (isHome || isHomeEdge || isLimit) begin
            finalNext = prof[homing_pkg::PROF_FINAL];
            riseNext = prof[homing_pkg::PROF_RISE];
            selNext = decSel;
            // index-based only for 1, 2 and 3-14
            useIndexNext = isHome || homingMethod == homing_pkg::METHOD_NEG_LIMIT_INDEX ||
              homingMethod == homing_pkg::METHOD_POS_LIMIT_INDEX;
            // 7-14 and 23-30 bounce off a limit, 3-6 and 19-22 stop on it
            reverseNext = (isHome && homingMethod > homing_pkg::METHOD_HOME_STOP_LAST) ||
              (isHomeEdge && homingMethod >
               8'(homing_pkg::METHOD_HOME_STOP_LAST + homing_pkg::METHOD_HOME_EDGE_OFFSET));
            fastApNext = homingMethod == homing_pkg::METHOD_NEG_LIMIT_EDGE ||
              homingMethod == homing_pkg::METHOD_POS_LIMIT_EDGE;
            bounceNext = 1'b0;
            dirNext = decStartDir;
            // already on the pre-edge side and heading the final way: approach at once (fast for 17 and 18, else slow)
            if (decLevel == ~prof[homing_pkg::PROF_RISE] &&
                decStartDir == prof[homing_pkg::PROF_FINAL]) begin
              stateNext = homing_pkg::ST_APPROACH;
            end else begin
              stateNext = homing_pkg::ST_SEEK;
            end
          end else begin
            stateNext = homing_pkg::ST_BAD;
          end
        end
      end
      homing_pkg::ST_SEEK: begin
        // entering the pre-edge level ends the fast search
        if (riseReg ? tgtFall : tgtRise) begin
          cntNext = 8'h00;
          stateNext = homing_pkg::ST_PAUSE;
        end else if (aheadLevel && !aheadIsTarget) begin
          // a second limit means no switch on the axis: stop rather than shuttle forever
          if (reverseReg && !bounceReg) begin
            dirNext = ~dirReg;
            bounceNext = 1'b1;
          end else begin
            stateNext = homing_pkg::ST_ALARM;
          end
        end
      end
      homing_pkg::ST_PAUSE: begin
        // motor ramps down here; no motion requested
        if (cntReg == 8'(homing_pkg::REVERSE_PAUSE_CYCLES - 8'h01)) begin
          dirNext = finalReg;
          stateNext = homing_pkg::ST_APPROACH;
        end else begin
          cntNext = 8'(cntReg + 8'h01);
        end
      end
      homing_pkg::ST_APPROACH: begin
        if (riseReg ? tgtRise : tgtFall) begin
          if (useIndexReg) begin
            stateNext = homing_pkg::ST_INDEX;
          end else begin
            latchNow = 1'b1;
            stateNext = homing_pkg::ST_FINISHED;
          end
        end else if (aheadLevel && !aheadIsTarget) begin
          stateNext = homing_pkg::ST_ALARM;
        end
      end
      homing_pkg::ST_INDEX: begin
        if (idxEdge.rise) begin
          latchNow = 1'b1;
          stateNext = homing_pkg::ST_FINISHED;
        end else if (aheadLevel) begin
          stateNext = homing_pkg::ST_ALARM;
        end
      end
      default: begin
        // finished, alarm and bad hold until the run word drops
      end
    endcase
    // dropping the control word aborts any run
    if (!homingRun) begin
      stateNext = homing_pkg::ST_IDLE;
    end
  end

  // outputs follow the next state so they leave flip-flops aligned with it
  always_comb begin
    busyNext = stateNext == homing_pkg::ST_SEEK || stateNext == homing_pkg::ST_PAUSE ||
      stateNext == homing_pkg::ST_APPROACH || stateNext == homing_pkg::ST_INDEX;
    movePosNext = busyNext && stateNext != homing_pkg::ST_PAUSE && dirNext;
    moveNegNext = busyNext && stateNext != homing_pkg::ST_PAUSE && !dirNext;
    fastNext = stateNext == homing_pkg::ST_SEEK ||
      (stateNext == homing_pkg::ST_APPROACH && fastApNext);
    doneNext = stateNext == homing_pkg::ST_FINISHED;
    alarmNext = stateNext == homing_pkg::ST_ALARM;
    invalidNext = stateNext == homing_pkg::ST_BAD;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stateReg <= homing_pkg::ST_IDLE;
      dirReg <= 1'b0;
      finalReg <= 1'b0;
      riseReg <= 1'b0;
      selReg <= homing_pkg::SENSE_HOME;
      useIndexReg <= 1'b0;
      reverseReg <= 1'b0;
      bounceReg <= 1'b0;
      fastApReg <= 1'b0;
      cntReg <= 8'h00;
      runPrevReg <= 1'b0;
      moveNegative <= 1'b0;
      movePositive <= 1'b0;
      fastSpeed <= 1'b0;
      homingBusy <= 1'b0;
      homingDone <= 1'b0;
      homingAlarm <= 1'b0;
      invalidMethod <= 1'b0;
    end else begin
      stateReg <= stateNext;
      dirReg <= dirNext;
      finalReg <= finalNext;
      riseReg <= riseNext;
      selReg <= selNext;
      useIndexReg <= useIndexNext;
      reverseReg <= reverseNext;
      bounceReg <= bounceNext;
      fastApReg <= fastApNext;
      cntReg <= cntNext;
      runPrevReg <= runPrevNext;
      moveNegative <= moveNegNext;
      movePositive <= movePosNext;
      fastSpeed <= fastNext;
      homingBusy <= busyNext;
      homingDone <= doneNext;
      homingAlarm <= alarmNext;
      invalidMethod <= invalidNext;
    end
  end

  // a new run forgets the previous origin unless it latches one at once
  // an abort in the latch cycle leaves no stray origin behind
  origin_latch originHold (
    .clock(clock),
    .rst(rst),
    .clear(startNow && stateReg == homing_pkg::ST_IDLE),
    .capture(latchNow && homingRun),
    .position(actualPosition),
    .originPosition(originPosition),
    .originValid(originValid)
  );
endmodule

//--- verilog/homing_pkg.sv
// constants shared by the homing sequencer and its helpers
// assumes one 100 MHz clock and sensor levels already synchronous to it
package homing_pkg;

  // method codes
  localparam logic [7:0] METHOD_NONE = 8'h00;
  localparam logic [7:0] METHOD_NEG_LIMIT_INDEX = 8'h01;
  localparam logic [7:0] METHOD_POS_LIMIT_INDEX = 8'h02;
  localparam logic [7:0] METHOD_HOME_FIRST = 8'h03;
  localparam logic [7:0] METHOD_HOME_STOP_LAST = 8'h06;
  localparam logic [7:0] METHOD_HOME_LAST = 8'h0E;
  localparam logic [7:0] METHOD_NEG_LIMIT_EDGE = 8'h11;
  localparam logic [7:0] METHOD_POS_LIMIT_EDGE = 8'h12;
  localparam logic [7:0] METHOD_HOME_EDGE_FIRST = 8'h13;
  localparam logic [7:0] METHOD_HOME_EDGE_LAST = 8'h1E;
  localparam logic [7:0] METHOD_HOME_EDGE_OFFSET = 8'h10;
  localparam logic [7:0] METHOD_INDEX_NEG = 8'h21;
  localparam logic [7:0] METHOD_INDEX_POS = 8'h22;
  localparam logic [7:0] METHOD_HERE = 8'h23;

  // which sensor carries the target edge
  localparam logic [1:0] SENSE_HOME = 2'h0;
  localparam logic [1:0] SENSE_NEG = 2'h1;
  localparam logic [1:0] SENSE_POS = 2'h2;

  // profile bits: {dir if sensor off, dir if sensor on, final dir, target is rising}
  localparam int PROF_DIR_OFF = 3;
  localparam int PROF_DIR_ON = 2;
  localparam int PROF_FINAL = 1;
  localparam int PROF_RISE = 0;

  localparam int POSITION_W = 32;

  // stop-and-reverse pause before the approach (slow except for methods 17 and 18)
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int REVERSE_PAUSE_NS = 1000;
  localparam logic [7:0] REVERSE_PAUSE_CYCLES =
    8'((REVERSE_PAUSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_PAUSE, ST_APPROACH, ST_INDEX, ST_FINISHED, ST_ALARM, ST_BAD
  } home_state_e;

  // direction 1 means positive
  function automatic logic [3:0] methodProfile(input logic [7:0] m);
    logic [7:0] idx;
    idx = (m >= METHOD_HOME_EDGE_FIRST) ? 8'(m - METHOD_HOME_EDGE_OFFSET) : m;
    case (idx)
      8'h01: methodProfile = 4'h6;
      8'h02: methodProfile = 4'h8;
      8'h11: methodProfile = 4'h5;
      8'h12: methodProfile = 4'hB;
      8'h03: methodProfile = 4'h8;
      8'h04: methodProfile = 4'hB;
      8'h05: methodProfile = 4'h6;
      8'h06: methodProfile = 4'h5;
      8'h07: methodProfile = 4'h8;
      8'h08: methodProfile = 4'hB;
      8'h09: methodProfile = 4'hD;
      8'h0A: methodProfile = 4'hE;
      8'h0B: methodProfile = 4'h6;
      8'h0C: methodProfile = 4'h5;
      8'h0D: methodProfile = 4'h3;
      8'h0E: methodProfile = 4'h0;
      default: methodProfile = 4'h0;
    endcase
  endfunction

endpackage

//--- verilog/sensor_edge_if.sv
// level and edge pulses of one sensor, passed from detector to sequencer
// assumes the detector and the sequencer share one clock
`timescale 1ns/10ps
interface sensor_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport drive (output level, output rise, output fall);
  modport sink (input level, input rise, input fall);
endinterface

//--- verilog/sensor_edge.sv
// edge detector for one synchronous sensor level
// assumes the input is already synchronous to clock
`timescale 1ns/10ps
module sensor_edge (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // sensor
  input wire logic sense,
  sensor_edge_if.drive port
);
  logic prevReg;
  logic prevNext;

  always_comb begin
    prevNext = sense;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prevReg <= 1'b0;
    end else begin
      prevReg <= prevNext;
    end
  end

  // off-to-on is rise, on-to-off is fall
  assign port.level = sense;
  assign port.rise = sense & ~prevReg;
  assign port.fall = ~sense & prevReg;
endmodule

//--- verilog/origin_latch.sv
// holds the captured origin position
// assumes capture is a one-cycle strobe from the sequencer
`timescale 1ns/10ps
module origin_latch (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic capture,
  input wire logic [homing_pkg::POSITION_W-1:0] position,
  // result
  output logic [homing_pkg::POSITION_W-1:0] originPosition,
  output logic originValid
);
  logic [homing_pkg::POSITION_W-1:0] posNext;
  logic validNext;

  always_comb begin
    posNext = originPosition;
    validNext = originValid;
    if (capture) begin
      posNext = position;
      validNext = 1'b1;
    end else if (clear) begin
      validNext = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      originPosition <= '0;
      originValid <= 1'b0;
    end else begin
      originPosition <= posNext;
      originValid <= validNext;
    end
  end
endmodule

//--- tb/axis_sensor_model.sv
// axis with two overtravel ends, a home switch and index marks
// assumes motion requests change on the rising clock edge
`timescale 1ns/10ps
module axis_sensor_model #(
  parameter int NEG_END = -200,
  parameter int POS_END = 200,
  parameter int HOME_LO = 0,
  parameter int HOME_HI = 40,
  parameter int PITCH = 50
) (
  // clock
  input wire logic clock,
  // motion and preset
  input wire logic moveNegative,
  input wire logic movePositive,
  input wire logic load,
  input wire logic [31:0] loadPos,
  // sensors
  output logic [31:0] position,
  output logic homeSwitchInput,
  output logic negativeOvertravelInput,
  output logic positiveOvertravelInput,
  output logic indexPulse
);
  int pos = 0;
  // one count a cycle; speed flag ignored, so edges land on exact counts
  always @(posedge clock) begin
    if (load) begin
      pos <= $signed(loadPos);
    end else if (moveNegative && !movePositive) begin
      pos <= pos - 1;
    end else if (movePositive && !moveNegative) begin
      pos <= pos + 1;
    end
  end
  assign position = 32'(pos);
  // on is high; switch covers a small slice of travel
  assign homeSwitchInput = (pos >= HOME_LO) && (pos <= HOME_HI);
  assign negativeOvertravelInput = pos <= NEG_END;
  assign positiveOvertravelInput = pos >= POS_END;
  assign indexPulse = (pos % PITCH) == 0;
endmodule

//--- tb/homing_method_sequencer_properties.sv
// port assertions for the homing sequencer
// assumes one clock and rst asynchronous active high
`timescale 1ns/10ps
module homing_method_sequencer_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // inputs
  input wire logic [7:0] homingMethod,
  input wire logic homingRun,
  input wire logic negativeOvertravelInput,
  input wire logic positiveOvertravelInput,
  input wire logic [homing_pkg::POSITION_W-1:0] actualPosition,
  // outputs
  input wire logic moveNegative,
  input wire logic movePositive,
  input wire logic fastSpeed,
  input wire logic homingDone,
  input wire logic homingAlarm,
  input wire logic invalidMethod,
  input wire logic [homing_pkg::POSITION_W-1:0] originPosition,
  input wire logic originValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_here_origin: assert property ($rose(homingRun) && homingMethod == 8'h23 |=>
    homingDone && originValid && originPosition == $past(actualPosition))
    else $error("origin not taken in place");
  chk_none_idle: assert property ($rose(homingRun) && homingMethod == 8'h00 |=>
    homingDone && !originValid && !moveNegative && !movePositive)
    else $error("method zero not idle");
  chk_reserved_refused: assert property ($rose(homingRun) &&
    (homingMethod == 8'h10 || homingMethod == 8'h1F || homingMethod == 8'h20) |=>
    invalidMethod && !moveNegative && !movePositive)
    else $error("reserved code moved");
  chk_index_negative: assert property ($rose(homingRun) && homingMethod == 8'h21 |=>
    moveNegative && !movePositive) else $error("method 33 wrong way");
  chk_index_positive: assert property ($rose(homingRun) && homingMethod == 8'h22 |=>
    movePositive && !moveNegative) else $error("method 34 wrong way");
  chk_neg_fast_start: assert property ($rose(homingRun) && homingMethod == 8'h01 &&
    !negativeOvertravelInput |=> moveNegative && fastSpeed) else $error("method 1 start");
  chk_neg_slow_start: assert property ($rose(homingRun) && homingMethod == 8'h01 &&
    negativeOvertravelInput |=> movePositive && !fastSpeed) else $error("method 1 on start");
  chk_pos_fast_start: assert property ($rose(homingRun) && homingMethod == 8'h02 &&
    !positiveOvertravelInput |=> movePositive && fastSpeed) else $error("method 2 start");
  chk_alarm_stops: assert property (homingAlarm |-> !moveNegative && !movePositive)
    else $error("moving during alarm");
  chk_done_stops: assert property (homingDone |-> !moveNegative && !movePositive)
    else $error("moving after done");
  chk_abort_stops: assert property ($fell(homingRun) |-> ##[1:2]
    (!moveNegative && !movePositive)) else $error("abort did not stop");
  cover property ($rose(homingDone) && originValid);
  cover property ($rose(homingAlarm));
  cover property ($rose(invalidMethod));
endmodule
bind homing_method_sequencer homing_method_sequencer_checker chk (.clock, .rst,
  .homingMethod, .homingRun, .negativeOvertravelInput, .positiveOvertravelInput,
  .actualPosition, .moveNegative, .movePositive, .fastSpeed, .homingDone, .homingAlarm,
  .invalidMethod, .originPosition, .originValid);

//--- tb/tb.sv
// self-checking bench for the homing sequencer
// assumes the axis model drives all sensors and the position
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] homingMethod = 8'h00;
  logic homingRun = 1'b0;
  logic loadAxis = 1'b0;
  logic [31:0] loadPos = 32'h0;
  logic homeSw, negLim, posLim, index;
  logic [31:0] pos, originPosition;
  logic moveNegative, movePositive, fastSpeed, homingBusy;
  logic homingDone, homingAlarm, invalidMethod, originValid;
  logic firstNeg, firstPos, firstFast, firstBusy;
  int fails = 0;
  int checks = 0;
  always #5 clock = ~clock;
  axis_sensor_model axis (.clock(clock), .moveNegative(moveNegative),
    .movePositive(movePositive), .load(loadAxis), .loadPos(loadPos), .position(pos),
    .homeSwitchInput(homeSw), .negativeOvertravelInput(negLim),
    .positiveOvertravelInput(posLim), .indexPulse(index));
  homing_method_sequencer DUT (.clock(clock), .rst(rst), .homingMethod(homingMethod),
    .homingRun(homingRun), .homeSwitchInput(homeSw), .negativeOvertravelInput(negLim),
    .positiveOvertravelInput(posLim), .indexPulse(index), .actualPosition(pos),
    .moveNegative(moveNegative), .movePositive(movePositive), .fastSpeed(fastSpeed),
    .homingBusy(homingBusy), .homingDone(homingDone), .homingAlarm(homingAlarm),
    .invalidMethod(invalidMethod), .originPosition(originPosition),
    .originValid(originValid));
  task automatic summarize();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic checkBit(input logic a, input logic e);
    checks++;
    if (a !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic checkVal(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  // capture lands within two counts of the sensed mark
  task automatic checkNear(input logic [31:0] a, input int e);
    logic [31:0] d;
    d = a - 32'(e) + 32'h2;
    checks++;
    if (^a === 1'bx || !(d <= 32'h4) || homingDone !== 1'b1 || originValid !== 1'b1) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, 32'(e));
    end
  endtask
  task automatic home(input logic [7:0] m, input int p);
    int n;
    @(negedge clock);
    loadAxis = 1'b1;
    loadPos = 32'(p);
    @(negedge clock);
    loadAxis = 1'b0;
    homingMethod = m;
    homingRun = 1'b1;
    @(negedge clock);
    firstNeg = moveNegative;
    firstPos = movePositive;
    firstFast = fastSpeed;
    firstBusy = homingBusy;
    n = 0;
    while (homingDone !== 1'b1 && homingAlarm !== 1'b1 && invalidMethod !== 1'b1
      && n < 3000) begin
      @(negedge clock);
      n++;
    end
    checkBit(n < 3000, 1'b1);
  endtask
  task automatic stopRun();
    @(negedge clock);
    homingRun = 1'b0;
    repeat (3) @(negedge clock);
    checkBit(homingDone | homingAlarm | invalidMethod | moveNegative | movePositive, 1'b0);
    checkBit(homingBusy, 1'b0);
  endtask
  task automatic testSimple();
    logic [7:0] bad [3] = '{8'h10, 8'h1F, 8'h20};
    home(8'h23, 77);
    checkBit(firstNeg | firstPos | firstBusy, 1'b0);
    checkBit(originValid, 1'b1);
    checkVal(originPosition, 32'h4D);
    stopRun();
    home(8'h00, 5);
    checkBit(homingDone, 1'b1);
    checkBit(originValid | firstNeg | firstPos, 1'b0);
    stopRun();
    foreach (bad[i]) begin
      home(bad[i], 5);
      checkBit(invalidMethod, 1'b1);
      checkBit(firstNeg | firstPos, 1'b0);
      stopRun();
    end
  endtask
  task automatic testLimits();
    home(8'h01, 100);
    checkBit(firstNeg & firstFast & firstBusy, 1'b1);
    checkNear(originPosition, -150);
    stopRun();
    home(8'h01, -210);
    checkBit(firstPos & !firstFast, 1'b1);
    checkNear(originPosition, -150);
    stopRun();
    home(8'h02, 100);
    checkBit(firstPos & firstFast, 1'b1);
    checkNear(originPosition, 150);
    stopRun();
    home(8'h02, 210);
    checkBit(firstNeg & !firstFast, 1'b1);
    checkNear(originPosition, 150);
    stopRun();
    home(8'h11, 100);
    checkBit(firstNeg, 1'b1);
    checkNear(originPosition, -200);
    stopRun();
    home(8'h12, 100);
    checkNear(originPosition, 200);
    stopRun();
  endtask
  task automatic testHome();
    home(8'h03, -100);
    checkBit(firstPos & firstFast, 1'b1);
    checkNear(originPosition, -50);
    stopRun();
    home(8'h03, 20);
    checkBit(firstNeg & !firstFast, 1'b1);
    checkNear(originPosition, -50);
    stopRun();
    home(8'h13, -100);
    checkNear(originPosition, -1);
    stopRun();
    home(8'h17, 100);
    checkNear(originPosition, -1);
    stopRun();
  endtask
  task automatic testAlarm();
    logic [7:0] ms [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h13, 8'h14, 8'h15, 8'h16};
    int ps [8] = '{100, 100, -100, -100, 100, 100, -100, -100};
    foreach (ms[i]) begin
      home(ms[i], ps[i]);
      checkBit(homingAlarm, 1'b1);
      checkBit(originValid | moveNegative | movePositive, 1'b0);
      stopRun();
    end
  endtask
  task automatic testIndex();
    home(8'h21, 120);
    checkBit(firstNeg & !firstPos, 1'b1);
    checkNear(originPosition, 100);
    stopRun();
    home(8'h22, 120);
    checkBit(firstPos & !firstNeg, 1'b1);
    checkNear(originPosition, 150);
    stopRun();
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    testSimple();
    testLimits();
    testHome();
    testAlarm();
    testIndex();
    summarize();
  end
  // about 25 runs of at most three thousand cycles each
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    summarize();
  end
endmodule
